/* File: rtl/agpm_top.sv */
`timescale 1ns/1ps
`include "agpm_cfg.svh"

module agpm_top import agpm_pkg::*; (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Converter samples, one per clock per channel
    input  wire logic [1:0][13:0] adc_sample_in,
    input  wire logic [1:0][2:0]  fast_mag_in,
    // Register port
    input  wire agpm_reg_req_t    reg_req_in,
    output logic [7:0]            reg_rdata_out,
    output logic                  reg_rvalid_out,
    // Gain control indicators
    output logic [1:0]            fine_low_indicator_out,
    output logic [1:0]            raise_gain_indicator_out,
    output logic [1:0]            lower_gain_indicator_out,
    // Feed towards the serial result port
    output logic [1:0][19:0]      peak_result_out,
    output logic [1:0]            peak_strobe_out
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Shared by the fine indicator path and the peak path of each channel
    // Absolute value clipped to 13 bits; full negative scale reads 8191
    function automatic logic [12:0] mag13(input logic [13:0] s);
        logic [13:0] a;
        a = s[13] ? (~s + 14'h0001) : s;
        if (a[13]) begin
            mag13 = 13'h1FFF;
        end else begin
            mag13 = a[12:0];
        end
    endfunction

    // Larger of two magnitudes
    function automatic logic [12:0] max13(input logic [12:0] a, input logic [12:0] b);
        max13 = (a > b) ? a : b;
    endfunction

    // A zero period would never hit one, so it behaves as one
    function automatic logic [23:0] eff_period(input logic [23:0] p);
        eff_period = (p == 24'h000000) ? 24'h000001 : p;
    endfunction

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    agpm_cfg_t cfg;

    agpm_regs u_regs (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .reg_req_in (reg_req_in),
        .cfg_out    (cfg)
    );

    // ****************************************************************
    // Shared monitor controls
    // ****************************************************************
    logic       mon_enable;
    logic [1:0] mon_mode;
    logic       peak_active;
    logic [15:0] dwell_eff;

    assign mon_enable = cfg.mon_ctrl[`AGPM_MON_EN_BIT];
    assign mon_mode   = cfg.mon_ctrl[`AGPM_MON_MODE_MSB:`AGPM_MON_MODE_LSB];
    // With the monitor enabled, mode one or the serial peak enable starts the peak detector
    assign peak_active = mon_enable &&
                         ((mon_mode == `AGPM_MODE_PEAK) ||
                          cfg.serial_result_port_ctrl[`AGPM_SERIAL_RESULT_PORT_PEAK_BIT]);
    // A dwell of zero is not a legal setting; treat it as one cycle
    assign dwell_eff = (cfg.dwell == 16'h0000) ? 16'h0001 : cfg.dwell;

    // Per channel results, visible to the register read mux
    logic [1:0][19:0] result_hold;

    // ****************************************************************
    // Per channel datapath
    // ****************************************************************
    // Both channels run the same mode; one shared mode field drives both
    // Each channel owns its flags, dwell count, period timer and peak
    // Only the configuration is shared, so a hot input on one channel
    // can never disturb the flags or results of the other
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan

        logic [12:0]     mag_q;
        logic [1:0]      fine_hold;
        logic [1:0]      raise_hold;
        logic [1:0]      lower_hold;
        logic [15:0]     dwell_cnt;
        logic [15:0]     next_dwell_cnt;
        logic            below;
        logic            raise_cond;
        logic            lower_cond;
        logic signed [13:0] corr_sample;
        logic [12:0]     corr_mag;
        agpm_mon_state_t mon_state;
        logic [23:0]     period_timer;
        logic [12:0]     peak_level;
        logic [12:0]     peak_now;

        // Full resolution magnitude, one stage of pipeline latency
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                mag_q <= 13'h0000;
            end else begin
                mag_q <= mag13(adc_sample_in[ch]);
            end
        end

        // The fine path sits two edges behind the sample and the lower gain
        // path one, so an overrange warning always leads the fine flags
        // Fine comparison against the 13-bit lower threshold
        assign below = (mag_q < cfg.fine_lo_thr);

        // Consecutive cycles below; any sample at or above restarts it
        assign next_dwell_cnt = !below ? 16'h0000 :
                                (dwell_cnt == 16'hFFFF) ? dwell_cnt :
                                dwell_cnt + 16'h0001;

        assign raise_cond = below && (next_dwell_cnt >= dwell_eff);

        // Fast path compare uses only the 3-bit coarse magnitude
        assign lower_cond = (fast_mag_in[ch] > cfg.coarse_thr);

        // Dwell counter
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                dwell_cnt <= 16'h0000;
            end else begin
                dwell_cnt <= next_dwell_cnt;
            end
        end

        // Fine low indicator with minimum on time
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                fine_low_indicator_out[ch] <= 1'b0;
                fine_hold                  <= 2'd0;
            end else if (below) begin
                fine_low_indicator_out[ch] <= 1'b1;
                fine_hold                  <= `AGPM_MIN_ACTIVE_CYC - 2'd1;
            end else if (fine_hold != 2'd0) begin
                fine_hold                  <= fine_hold - 2'd1;
            end else begin
                fine_low_indicator_out[ch] <= 1'b0;
            end
        end

        // Raise gain indicator with minimum on time
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                raise_gain_indicator_out[ch] <= 1'b0;
                raise_hold                   <= 2'd0;
            end else if (raise_cond) begin
                raise_gain_indicator_out[ch] <= 1'b1;
                raise_hold                   <= `AGPM_MIN_ACTIVE_CYC - 2'd1;
            end else if (raise_hold != 2'd0) begin
                raise_hold                   <= raise_hold - 2'd1;
            end else begin
                raise_gain_indicator_out[ch] <= 1'b0;
            end
        end

        // Lower gain indicator; one cycle from the fast magnitude input
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                lower_gain_indicator_out[ch] <= 1'b0;
                lower_hold                   <= 2'd0;
            end else if (lower_cond) begin
                lower_gain_indicator_out[ch] <= 1'b1;
                lower_hold                   <= `AGPM_MIN_ACTIVE_CYC - 2'd1;
            end else if (lower_hold != 2'd0) begin
                lower_hold                   <= lower_hold - 2'd1;
            end else begin
                lower_gain_indicator_out[ch] <= 1'b0;
            end
        end

        // Indicators use raw samples so their latency never depends on this
        // Dc correction ahead of the monitor
        agpm_dccorr u_dccorr (
            .clk_in     (clk_in),
            .rst_in     (rst_in),
            .enable_in  (mon_enable),
            .sample_in  (adc_sample_in[ch]),
            .sample_out (corr_sample)
        );

        assign corr_mag = mag13(corr_sample);
        // Peak including this cycle's sample; a seed cycle takes the sample alone
        assign peak_now = (mon_state == AGPM_MON_SEED) ? corr_mag :
                          max13(peak_level, corr_mag);

        // Peak monitor sequence: idle, seed on first sample, then run
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                mon_state <= AGPM_MON_IDLE;
            end else if (!peak_active) begin
                mon_state <= AGPM_MON_IDLE;
            end else begin
                unique case (mon_state)
                    AGPM_MON_IDLE: mon_state <= AGPM_MON_SEED;
                    AGPM_MON_SEED,
                    AGPM_MON_RUN: begin
                        if (period_timer == 24'h000001) begin
                            mon_state <= AGPM_MON_SEED;
                        end else begin
                            mon_state <= AGPM_MON_RUN;
                        end
                    end
                    default: mon_state <= AGPM_MON_IDLE;
                endcase
            end
        end

        // The timer never rests at zero: a zero setting would otherwise
        // leave the result register frozen for good
        // Period timer: loaded on start, reloaded when it reaches one
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                period_timer <= 24'h000001;
            end else if (mon_state == AGPM_MON_IDLE) begin
                period_timer <= eff_period(cfg.period);
            end else if (period_timer == 24'h000001) begin
                period_timer <= eff_period(cfg.period);
            end else begin
                period_timer <= period_timer - 24'h000001;
            end
        end

        // Internal peak level register
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                peak_level <= 13'h0000;
            end else if (mon_state != AGPM_MON_IDLE) begin
                peak_level <= peak_now;
            end
        end

        // The register copy always updates; the serial copy only when enabled
        // Holding register and serial feed at the end of each period
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                result_hold[ch]     <= 20'h00000;
                peak_result_out[ch] <= 20'h00000;
                peak_strobe_out[ch] <= 1'b0;
            end else begin
                peak_strobe_out[ch] <= 1'b0;
                if (mon_state != AGPM_MON_IDLE && period_timer == 24'h000001) begin
                    result_hold[ch] <= {7'h00, peak_now};
                    if (cfg.serial_result_port_ctrl[`AGPM_SERIAL_RESULT_PORT_PEAK_BIT]) begin
                        peak_result_out[ch] <= {7'h00, peak_now};
                        peak_strobe_out[ch] <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Register read back
    // ****************************************************************
    logic [7:0]  next_rdata;
    logic [19:0] shown_a;
    logic [19:0] shown_b;

    // Result bytes are not shadowed: a period may end between two byte
    // reads, so software wanting a coherent value reads it twice
    // and keeps the pair that agrees
    // Only the peak measurement exists here; other modes read zero
    assign shown_a = (mon_mode == `AGPM_MODE_PEAK) ? result_hold[0] : 20'h00000;
    assign shown_b = (mon_mode == `AGPM_MODE_PEAK) ? result_hold[1] : 20'h00000;

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_req_in.addr)
            `AGPM_ADDR_COARSE_THR:   next_rdata = {5'h00, cfg.coarse_thr};
            `AGPM_ADDR_FINE_LO_LOW:  next_rdata = cfg.fine_lo_thr[7:0];
            `AGPM_ADDR_FINE_LO_HIGH: next_rdata = {3'h0, cfg.fine_lo_thr[12:8]};
            `AGPM_ADDR_DWELL_LOW:    next_rdata = cfg.dwell[7:0];
            `AGPM_ADDR_DWELL_HIGH:   next_rdata = cfg.dwell[15:8];
            `AGPM_ADDR_SERIAL_RESULT_PORT_CTRL:   next_rdata = {5'h00, cfg.serial_result_port_ctrl};
            `AGPM_ADDR_MON_CTRL:     next_rdata = {4'h0, cfg.mon_ctrl};
            `AGPM_ADDR_PERIOD_B0:    next_rdata = cfg.period[7:0];
            `AGPM_ADDR_PERIOD_B1:    next_rdata = cfg.period[15:8];
            `AGPM_ADDR_PERIOD_B2:    next_rdata = cfg.period[23:16];
            `AGPM_ADDR_RESULT_FIRST: next_rdata = shown_a[7:0];
            10'h117:                 next_rdata = shown_a[15:8];
            10'h118:                 next_rdata = {4'h0, shown_a[19:16]};
            10'h119:                 next_rdata = shown_b[7:0];
            10'h11A:                 next_rdata = shown_b[15:8];
            `AGPM_ADDR_RESULT_LAST:  next_rdata = {4'h0, shown_b[19:16]};
            default:                 next_rdata = 8'h00;
        endcase
    end

    // Read data registered, valid one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

endmodule

/* File: rtl/agpm_cfg.svh */
`ifndef AGPM_CFG_SVH
`define AGPM_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AGPM_ADDR_COARSE_THR     10'h105
`define AGPM_ADDR_FINE_LO_LOW    10'h108
`define AGPM_ADDR_FINE_LO_HIGH   10'h109
`define AGPM_ADDR_DWELL_LOW      10'h10A
`define AGPM_ADDR_DWELL_HIGH     10'h10B
`define AGPM_ADDR_SERIAL_RESULT_PORT_CTRL     10'h111
`define AGPM_ADDR_MON_CTRL       10'h112
`define AGPM_ADDR_PERIOD_B0      10'h113
`define AGPM_ADDR_PERIOD_B1      10'h114
`define AGPM_ADDR_PERIOD_B2      10'h115
`define AGPM_ADDR_RESULT_FIRST   10'h116
`define AGPM_ADDR_RESULT_LAST    10'h11B

// ****************************************************************
// Field positions
// ****************************************************************
`define AGPM_MON_EN_BIT          0
`define AGPM_MON_MODE_LSB        1
`define AGPM_MON_MODE_MSB        2
`define AGPM_SERIAL_RESULT_PORT_RMS_BIT       0
`define AGPM_SERIAL_RESULT_PORT_PEAK_BIT      1
`define AGPM_SERIAL_RESULT_PORT_THR_BIT       2
`define AGPM_MODE_PEAK           2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define AGPM_RST_COARSE_THR      3'h0
`define AGPM_RST_FINE_LO_THR     13'h0000
`define AGPM_RST_DWELL           16'h0001
`define AGPM_RST_SERIAL_RESULT_PORT_CTRL      3'h0
`define AGPM_RST_MON_CTRL        4'h0
`define AGPM_RST_PERIOD          24'h000080

// ****************************************************************
// Minimum on time in sample clock cycles, and the dc filter shift in bits
// ****************************************************************
`define AGPM_MIN_ACTIVE_CYC      2'd2
`define AGPM_DC_SHIFT            10

`endif

/* File: rtl/agpm_pkg.sv */
package agpm_pkg;

    // Register port request, one access per cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } agpm_reg_req_t;

    // Configuration seen by the monitor logic
    typedef struct packed {
        logic [2:0]  coarse_thr;
        logic [12:0] fine_lo_thr;
        logic [15:0] dwell;
        logic [2:0]  serial_result_port_ctrl;
        logic [3:0]  mon_ctrl;
        logic [23:0] period;
    } agpm_cfg_t;

    // Peak monitor sequence per channel
    typedef enum logic [2:0] {
        AGPM_MON_IDLE = 3'b001,
        AGPM_MON_SEED = 3'b010,
        AGPM_MON_RUN  = 3'b100
    } agpm_mon_state_t;

endpackage

/* File: rtl/agpm_regs.sv */
`timescale 1ns/1ps
`include "agpm_cfg.svh"

module agpm_regs import agpm_pkg::*; (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // Register port
    input  wire agpm_reg_req_t reg_req_in,
    // Stored configuration
    output agpm_cfg_t          cfg_out
);

    // ****************************************************************
    // Byte writes into the configuration fields
    // ****************************************************************
    // Unused upper bits of narrow registers are simply not stored
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_out.coarse_thr  <= `AGPM_RST_COARSE_THR;
            cfg_out.fine_lo_thr <= `AGPM_RST_FINE_LO_THR;
            cfg_out.dwell       <= `AGPM_RST_DWELL;
            cfg_out.serial_result_port_ctrl  <= `AGPM_RST_SERIAL_RESULT_PORT_CTRL;
            cfg_out.mon_ctrl    <= `AGPM_RST_MON_CTRL;
            cfg_out.period      <= `AGPM_RST_PERIOD;
        end else if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                `AGPM_ADDR_COARSE_THR:  cfg_out.coarse_thr         <= reg_req_in.wdata[2:0];
                `AGPM_ADDR_FINE_LO_LOW: cfg_out.fine_lo_thr[7:0]   <= reg_req_in.wdata;
                `AGPM_ADDR_FINE_LO_HIGH: cfg_out.fine_lo_thr[12:8] <= reg_req_in.wdata[4:0];
                `AGPM_ADDR_DWELL_LOW:   cfg_out.dwell[7:0]         <= reg_req_in.wdata;
                `AGPM_ADDR_DWELL_HIGH:  cfg_out.dwell[15:8]        <= reg_req_in.wdata;
                `AGPM_ADDR_SERIAL_RESULT_PORT_CTRL:  cfg_out.serial_result_port_ctrl         <= reg_req_in.wdata[2:0];
                `AGPM_ADDR_MON_CTRL:    cfg_out.mon_ctrl           <= reg_req_in.wdata[3:0];
                `AGPM_ADDR_PERIOD_B0:   cfg_out.period[7:0]        <= reg_req_in.wdata;
                `AGPM_ADDR_PERIOD_B1:   cfg_out.period[15:8]       <= reg_req_in.wdata;
                `AGPM_ADDR_PERIOD_B2:   cfg_out.period[23:16]      <= reg_req_in.wdata;
                default: begin
                end
            endcase
        end
    end

endmodule

/* File: rtl/agpm_dccorr.sv */
`timescale 1ns/1ps
`include "agpm_cfg.svh"

module agpm_dccorr (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // Control
    input  wire logic               enable_in,
    // Samples
    input  wire logic signed [13:0] sample_in,
    output logic signed [13:0]      sample_out
);

    localparam int ACC_W = 14 + `AGPM_DC_SHIFT;

    logic signed [ACC_W-1:0] acc;
    logic signed [13:0]      dc_est;
    logic signed [14:0]      diff;

    // ****************************************************************
    // First order high-pass: the accumulator tracks the offset
    // ****************************************************************
    assign dc_est = acc[ACC_W-1:`AGPM_DC_SHIFT];
    assign diff   = 15'(sample_in) - 15'(dc_est);

    // Offset estimate, held at zero while the monitor is off to save power
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc <= '0;
        end else if (!enable_in) begin
            acc <= '0;
        end else begin
            acc <= acc + ACC_W'(diff);
        end
    end

    // Corrected sample, saturated so a large offset cannot wrap the sign
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_out <= '0;
        end else if (!enable_in) begin
            sample_out <= sample_in;
        end else if (diff > 15'sh1FFF) begin
            sample_out <= 14'sh1FFF;
        end else if (diff < -15'sh2000) begin
            sample_out <= -14'sh2000;
        end else begin
            sample_out <= diff[13:0];
        end
    end

endmodule

/* File: sim/agpm_top_monitor.sv */
`timescale 1ns/1ps
module agpm_top_monitor import agpm_pkg::*; (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Watched ports
    input  wire logic [1:0][13:0] adc_sample_in,
    input  wire logic [1:0][2:0]  fast_mag_in,
    input  wire agpm_reg_req_t    reg_req_in,
    input  wire logic             reg_rvalid_out,
    input  wire logic [1:0]       fine_low_indicator_out,
    input  wire logic [1:0]       raise_gain_indicator_out,
    input  wire logic [1:0]       lower_gain_indicator_out,
    input  wire logic [1:0][19:0] peak_result_out,
    input  wire logic [1:0]       peak_strobe_out
);
    // Full scale can never sit below a 13-bit threshold
    logic full0;
    assign full0 = adc_sample_in[0] == 14'h2000 || adc_sample_in[0] == 14'h1FFF;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_fine_full_off: assert property ($past(full0, 1) && $past(full0, 2) && $past(full0, 3)
        |-> !fine_low_indicator_out[0]) else $error("fine low set at full scale");
    a_lower_zero_off: assert property ($past(fast_mag_in[1]) == 3'h0
        && $past(fast_mag_in[1], 2) == 3'h0 |-> !lower_gain_indicator_out[1])
        else $error("lower gain set with zero fast magnitude");
    a_lower_min_on: assert property ($rose(lower_gain_indicator_out[0])
        |=> lower_gain_indicator_out[0]) else $error("lower gain pulse too short");
    a_fine_min_on: assert property ($rose(fine_low_indicator_out[1])
        |=> fine_low_indicator_out[1]) else $error("fine low pulse too short");
    a_raise_needs_fine: assert property (raise_gain_indicator_out[0]
        |-> fine_low_indicator_out[0]) else $error("raise gain without fine low");
    a_read_answer: assert property (reg_rvalid_out == $past(reg_req_in.rd))
        else $error("read answer timing wrong");
    a_result_held: assert property (!peak_strobe_out[0] |-> $stable(peak_result_out[0]))
        else $error("peak result moved without strobe");
    a_result_width: assert property (peak_result_out[1][19:13] == 7'h00)
        else $error("peak result upper bits set");
endmodule
bind agpm_top agpm_top_monitor agpm_top_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
    .adc_sample_in(adc_sample_in), .fast_mag_in(fast_mag_in), .reg_req_in(reg_req_in),
    .reg_rvalid_out(reg_rvalid_out), .fine_low_indicator_out(fine_low_indicator_out),
    .raise_gain_indicator_out(raise_gain_indicator_out),
    .lower_gain_indicator_out(lower_gain_indicator_out),
    .peak_result_out(peak_result_out), .peak_strobe_out(peak_strobe_out));

/* File: sim/agpm_src_model.sv */
`timescale 1ns/1ps
module agpm_src_model (
    // Wanted magnitude and sign
    input  wire logic [1:0][12:0] mag_in,
    input  wire logic [1:0]       neg_in,
    // Converter outputs
    output logic [1:0][13:0]      sample_out,
    output logic [1:0][2:0]       fast_out
);
    // Coarse magnitude is the top three bits, as a fast path would give
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sample_out[c] = neg_in[c] ? 14'(-{1'b0, mag_in[c]}) : {1'b0, mag_in[c]};
            fast_out[c]   = mag_in[c][12:10];
        end
    end
endmodule

/* File: sim/agpm_top_bench.sv */
`timescale 1ns/1ps
`include "agpm_cfg.svh"
module agpm_top_bench import agpm_pkg::*;;
    logic clk_in = 0, rst_in = 1, reg_rvalid_out;
    logic [1:0][12:0] mag = {13'h1FFF, 13'h1FFF};
    logic [1:0] neg = 2'h0, fine, rai, low, stb;
    logic [1:0][13:0] smp;
    logic [1:0][2:0] fst;
    logic [1:0][19:0] res;
    logic [7:0] rdata, d, e;
    agpm_reg_req_t req = '0;
    int failures = 0, num_checks = 0, seed = 32'hdd12, n;
    int acc_m [2] = '{0, 0}, pk [2] = '{0, 0}, cv;
    bit trk = 0, win = 0;
    logic [9:0] ra [8] = '{10'h105, 10'h108, 10'h10A, 10'h10B, 10'h112, 10'h113, 10'h115, 10'h100};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    always #5 clk_in = ~clk_in;
    agpm_src_model agpm_src_model_i (.mag_in(mag), .neg_in(neg), .sample_out(smp), .fast_out(fst));
    agpm_top agpm_top_i (.clk_in(clk_in), .rst_in(rst_in), .adc_sample_in(smp), .fast_mag_in(fst),
        .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(reg_rvalid_out),
        .fine_low_indicator_out(fine), .raise_gain_indicator_out(rai),
        .lower_gain_indicator_out(low), .peak_result_out(res), .peak_strobe_out(stb));
    // ********************
    // Checks and bus cycles
    // ********************
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Peak compare keeps a little slack around the modelled value
    task automatic near(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if ((^got) === 1'bx || got > exp + 20'd16 || got + 20'd16 < exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        req = '{1'b1, 1'b0, a, v};
        @(posedge clk_in) #1 req = '0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in) #1 req = '0;
        chk(reg_rvalid_out, 1'b1);
        v = rdata;
    endtask
    // Random signs each sample; a tracked run also models the offset follower
    task automatic drive(input int k, input logic [12:0] m0, input logic [12:0] m1);
        repeat (k) begin
            mag = {m1, m0};
            neg = 2'($random(seed));
            for (int j = 0; j < 2 && trk; j++) begin
                cv = (neg[j] ? -int'(mag[j]) : int'(mag[j])) - (acc_m[j] >>> `AGPM_DC_SHIFT);
                acc_m[j] += cv;
                if (win && (cv < 0 ? -cv : cv) > pk[j])
                    pk[j] = cv < 0 ? -cv : cv;
            end
            @(posedge clk_in) #1;
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        test_done;
    end
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (8) @(posedge clk_in);
        #1 rst_in = 0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], d);
            chk(d, rv[i]);
        end
        wr(10'h108, 8'h64);
        wr(10'h109, 8'h00);
        wr(10'h10A, 8'h05);
        wr(10'h105, 8'h03);
        drive(3, 13'd50, 13'h1FFF);
        chk(fine[0], 1'b1);
        chk(rai[0], 1'b0);
        chk(low, 2'b10);
        drive(5, 13'd50, 13'd3072);
        chk(rai[0], 1'b1);
        chk(low[1], 1'b0);
        drive(4, 13'd200, 13'd3072);
        chk({fine[0], rai[0]}, 2'b00);
        drive(4, 13'd50, 13'd3072);
        drive(1, 13'd200, 13'd3072);
        drive(3, 13'd50, 13'd3072);
        chk(rai[0], 1'b0);
        wr(10'h113, 8'h80);
        wr(10'h111, 8'h02);
        wr(10'h112, 8'h03);
        n = 0;
        trk = 1;
        // Second period holds samples 129 to 256
        for (int i = 0; i < 320; i++) begin
            n += stb[0];
            win = i >= 128 && i < 256;
            if (i % 64 == 7)
                drive(1, 13'd5000, 13'd4000);
            else
                drive(1, 13'({$random(seed)} % 3000), 13'({$random(seed)} % 3000));
        end
        chk(20'(n), 20'd2);
        near(res[0], 20'(pk[0]));
        near(res[1], 20'(pk[1]));
        rd(10'h116, d);
        rd(10'h117, e);
        near({4'h0, e, d}, 20'(pk[0]));
        wr(10'h112, 8'h01);
        rd(10'h116, d);
        chk(d, 8'h00);
        test_done;
    end
endmodule
